// ### rtl/timer3_params.svh
`ifndef TIMER3_PARAMS_SVH
`define TIMER3_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte addresses (one aligned word each, data in bits 7:0)
// ----------------------------------------------------------------------
`define OFS_PERIOD_LO 8'h00
`define OFS_PERIOD_HI 8'h04
`define OFS_COUNT_LO 8'h08
`define OFS_COUNT_HI 8'h0c
`define OFS_CAP2_LO 8'h10
`define OFS_CAP2_HI 8'h14
`define OFS_CTRL 8'h18
`define OFS_IRQ_EN 8'h1c
`define OFS_IRQ_REQ 8'h20
`define OFS_IRQ_CTRL 8'h24
`define OFS_PORT 8'h28

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_SELECT_BIT 0
`define CTRL_RUN_BIT 1
`define CTRL_EDGE_LO_BIT 2
`define CTRL_EDGE_HI_BIT 3
`define CTRL_OVF_BIT 4
`define IE_MATCH_BIT 6
`define IE_CAP2_BIT 3
`define IR_CAP1_BIT 2
`define INTC_PERIPHERAL_IRQ_ENABLE_BIT 0
`define INTC_GLOBAL_IRQ_DISABLE_BIT 1
`define INTC_SUMMARY_BIT 2
`define PORT_LEVEL_BIT 0
`define PORT_DIR_BIT 1

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define CTRL_RESET 4'h0
`define IE_RESET 8'h00
`define GLOBAL_IRQ_DISABLE_RESET 1'b1
`define PERIOD_RESET 16'hffff
`define COUNT_RESET 16'h0000
`define PRESCALE_4_LAST 4'h3
`define PRESCALE_16_LAST 4'hf

`endif

// ### rtl/timer3_pkg.sv
package timer3_pkg;

  typedef enum logic [1:0] {
    edge_fall = 2'b00,
    edge_rise = 2'b01,
    edge_rise4 = 2'b10,
    edge_rise16 = 2'b11
  } edge_sel_type;

  typedef enum logic [2:0] {
    bus_idle = 3'b001,
    bus_write = 3'b010,
    bus_read = 3'b100
  } bus_state_type;

endpackage : timer3_pkg

// ### rtl/capture_edge_detect.sv
`timescale 1ns/100ps
`include "timer3_params.svh"

module capture_edge_detect (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Capture level and selection
  input wire logic cap_level,
  input wire timer3_pkg::edge_sel_type edge_sel,
  // Event out
  output logic capture_event
);
  import timer3_pkg::*;

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic [3:0] prescale_reg;
  logic rise;
  logic fall;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= cap_level;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  // The prescaler counts rising edges and ignores changes of selection.
  // selection keeps prescaler
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale_reg <= 4'h0;
    end else if (rise) begin
      prescale_reg <= prescale_reg + 4'h1;
    end
  end

  always_comb begin
    case (edge_sel)
      edge_fall: capture_event = fall;
      edge_rise: capture_event = rise;
      edge_rise4: begin
        capture_event = rise & (prescale_reg[1:0] == 2'(`PRESCALE_4_LAST));
      end
      edge_rise16: capture_event = rise & (prescale_reg == `PRESCALE_16_LAST);
      default: capture_event = 1'b0;
    endcase
  end

endmodule : capture_edge_detect

// ### rtl/timer3_period_and_capture.sv
// Behaviour
// - Period mode: timer counts up to period value, then returns to zero.
// - Period mode is active whenever the mode select bit is clear.
// - Match and wrap sets the match flag; its enable gates the request.
// - First capture channel disabled; its flag never sets.
// - Second capture active on falling, rising, 4th or 16th rising edge.
// - A capture event copies the count into the capture pair unless the pair is still unread.
// - Each capture event sets the capture flag until software clears it.
// - Capture interrupt needs its enable, peripheral enable, no disable.
// - Changing edge selection leaves the prescaler alone.
// - Chip reset clears the capture prescaler.
// - Capture works in port use; output writes can trigger it.
// - Capture pin is synchronised before edge detection.
// - Event while capture unread sets the hidden master overflow.
// - Event while capture unread does not overwrite the capture value.
// - Reading both capture bytes moves master overflow to visible bit.
// - Match enable is bit 6 of the interrupt enable register.
// - Capture enable is bit 3 of the interrupt enable register.
// - Summary flag is OR of each request flag ANDed with its enable.
//
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
`include "timer3_params.svh"

module timer3_period_and_capture (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Shared capture pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // Interrupt requests
  output logic third_timer_match_req,
  output logic second_capture_irq,
  output logic peripheral_irq_summary_flag
);
  import timer3_pkg::*;

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  bus_state_type bus_state_reg;
  logic [7:0] addr_reg;
  logic accept;
  logic wr_en;
  logic rd_en;
  logic [7:0] wbyte;
  logic [7:0] rdata_next;

  logic [15:0] period_reg;
  logic [15:0] count_reg;
  logic [15:0] cap_reg;
  logic capture_or_period_select;
  logic timer_run;
  logic second_capture_edge_sel_hi;
  logic second_capture_edge_sel_lo;
  logic second_capture_overflow;
  logic ovf_master_reg;
  logic unread_reg;
  logic rd_lo_reg;
  logic rd_hi_reg;
  logic [7:0] irq_en_reg;
  logic third_timer_match_flag;
  logic second_capture_flag;
  logic first_capture_flag;
  logic peripheral_irq_enable;
  logic global_irq_disable;
  logic port_out_reg;
  logic port_dir_reg;

  logic period_mode;
  logic count_write;
  logic match_hit;
  logic cap_level;
  logic capture_event;
  logic rd_cap_lo;
  logic rd_cap_hi;
  logic both_done;
  logic [7:0] irq_req_vec;
  logic summary;

  // Register decode used by every write path and the capture byte reads.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  // --------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------
  assign accept = hsel & hready & htrans[1];

  // Reads take one wait state so that a write just before is seen.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_reg <= bus_idle;
      addr_reg <= 8'h00;
    end else begin
      case (bus_state_reg)
        bus_idle, bus_write: begin
          if (accept) begin
            bus_state_reg <= hwrite ? bus_write : bus_read;
            addr_reg <= haddr[7:0];
          end else begin
            bus_state_reg <= bus_idle;
          end
        end
        bus_read: bus_state_reg <= bus_idle;
        default: bus_state_reg <= bus_idle;
      endcase
    end
  end

  assign hreadyout = (bus_state_reg != bus_read);
  assign hresp = 1'b0;
  assign wr_en = (bus_state_reg == bus_write);
  assign rd_en = (bus_state_reg == bus_read);
  assign wbyte = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_en) begin
      hrdata <= {24'h00_0000, rdata_next};
    end
  end

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  // select clear is period mode
  assign period_mode = ~capture_or_period_select;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {second_capture_edge_sel_hi, second_capture_edge_sel_lo, timer_run,
       capture_or_period_select} <= `CTRL_RESET;
    end else if (wr_en && hit(addr_reg, `OFS_CTRL)) begin
      capture_or_period_select <= wbyte[`CTRL_SELECT_BIT];
      timer_run <= wbyte[`CTRL_RUN_BIT];
      second_capture_edge_sel_lo <= wbyte[`CTRL_EDGE_LO_BIT];
      second_capture_edge_sel_hi <= wbyte[`CTRL_EDGE_HI_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_reg <= `IE_RESET;
    end else if (wr_en && hit(addr_reg, `OFS_IRQ_EN)) begin
      irq_en_reg <= wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      peripheral_irq_enable <= 1'b0;
      global_irq_disable <= `GLOBAL_IRQ_DISABLE_RESET;
    end else if (wr_en && hit(addr_reg, `OFS_IRQ_CTRL)) begin
      peripheral_irq_enable <= wbyte[`INTC_PERIPHERAL_IRQ_ENABLE_BIT];
      global_irq_disable <= wbyte[`INTC_GLOBAL_IRQ_DISABLE_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_out_reg <= 1'b0;
      port_dir_reg <= 1'b0;
    end else if (wr_en && hit(addr_reg, `OFS_PORT)) begin
      port_out_reg <= wbyte[`PORT_LEVEL_BIT];
      port_dir_reg <= wbyte[`PORT_DIR_BIT];
    end
  end

  assign pin_out = port_out_reg;
  assign pin_oe = port_dir_reg;

  // --------------------------------------------------------------------
  // Period register and timer
  // --------------------------------------------------------------------
  // period bytes separately written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_reg <= `PERIOD_RESET;
    end else if (wr_en && hit(addr_reg, `OFS_PERIOD_LO)) begin
      period_reg[7:0] <= wbyte;
    end else if (wr_en && hit(addr_reg, `OFS_PERIOD_HI)) begin
      period_reg[15:8] <= wbyte;
    end
  end

  assign count_write = wr_en &&
      (hit(addr_reg, `OFS_COUNT_LO) || hit(addr_reg, `OFS_COUNT_HI));
  assign match_hit = timer_run & period_mode & ~count_write &
      (count_reg == period_reg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= `COUNT_RESET;
    end else if (wr_en && hit(addr_reg, `OFS_COUNT_LO)) begin
      count_reg[7:0] <= wbyte;
    end else if (wr_en && hit(addr_reg, `OFS_COUNT_HI)) begin
      count_reg[15:8] <= wbyte;
    end else if (match_hit) begin
      count_reg <= `COUNT_RESET;
    end else if (timer_run) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // --------------------------------------------------------------------
  // Capture path
  // --------------------------------------------------------------------
  // output latch loops back
  assign cap_level = port_dir_reg ? port_out_reg : pin_in;

  capture_edge_detect u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .cap_level(cap_level),
    .edge_sel(edge_sel_type'({second_capture_edge_sel_hi,
                              second_capture_edge_sel_lo})),
    .capture_event(capture_event)
  );

  assign rd_cap_lo = rd_en && hit(addr_reg, `OFS_CAP2_LO);
  assign rd_cap_hi = rd_en && hit(addr_reg, `OFS_CAP2_HI);
  assign both_done = unread_reg & (rd_lo_reg | rd_cap_lo) &
      (rd_hi_reg | rd_cap_hi);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_reg <= 16'h0000;
    end else if (capture_event && !unread_reg) begin
      cap_reg <= count_reg;
    end else if (wr_en && hit(addr_reg, `OFS_CAP2_LO)) begin
      cap_reg[7:0] <= wbyte;
    end else if (wr_en && hit(addr_reg, `OFS_CAP2_HI)) begin
      cap_reg[15:8] <= wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unread_reg <= 1'b0;
    end else if (capture_event && !unread_reg) begin
      unread_reg <= 1'b1;
    end else if (both_done) begin
      unread_reg <= 1'b0;
    end
  end

  // Byte reads are tracked so that either order completes the pair.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_lo_reg <= 1'b0;
      rd_hi_reg <= 1'b0;
    end else if (both_done || !unread_reg) begin
      rd_lo_reg <= 1'b0;
      rd_hi_reg <= 1'b0;
    end else begin
      rd_lo_reg <= rd_lo_reg | rd_cap_lo;
      rd_hi_reg <= rd_hi_reg | rd_cap_hi;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_master_reg <= 1'b0;
    end else if (capture_event && unread_reg) begin
      ovf_master_reg <= 1'b1;
    end else if (both_done) begin
      ovf_master_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_capture_overflow <= 1'b0;
    end else if (both_done) begin
      second_capture_overflow <= ovf_master_reg;
    end
  end

  // --------------------------------------------------------------------
  // Request flags
  // --------------------------------------------------------------------
  // match sets flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      third_timer_match_flag <= 1'b0;
    end else if (match_hit) begin
      third_timer_match_flag <= 1'b1;
    end else if (wr_en && hit(addr_reg, `OFS_IRQ_REQ)) begin
      third_timer_match_flag <= wbyte[`IE_MATCH_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_capture_flag <= 1'b0;
    end else if (capture_event) begin
      second_capture_flag <= 1'b1;
    end else if (wr_en && hit(addr_reg, `OFS_IRQ_REQ)) begin
      second_capture_flag <= wbyte[`IE_CAP2_BIT];
    end
  end

  assign first_capture_flag = 1'b0;

  always_comb begin
    irq_req_vec = 8'h00;
    irq_req_vec[`IE_MATCH_BIT] = third_timer_match_flag;
    irq_req_vec[`IE_CAP2_BIT] = second_capture_flag;
    irq_req_vec[`IR_CAP1_BIT] = first_capture_flag;
  end

  assign summary = |(irq_req_vec & irq_en_reg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      third_timer_match_req <= 1'b0;
      second_capture_irq <= 1'b0;
      peripheral_irq_summary_flag <= 1'b0;
    end else begin
      third_timer_match_req <= third_timer_match_flag &
          irq_en_reg[`IE_MATCH_BIT];
      second_capture_irq <= second_capture_flag & irq_en_reg[`IE_CAP2_BIT] &
          peripheral_irq_enable & ~global_irq_disable;
      peripheral_irq_summary_flag <= summary;
    end
  end

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  // byte-wide read access
  always_comb begin
    rdata_next = 8'h00;
    case (addr_reg)
      `OFS_PERIOD_LO: rdata_next = period_reg[7:0];
      `OFS_PERIOD_HI: rdata_next = period_reg[15:8];
      `OFS_COUNT_LO: rdata_next = count_reg[7:0];
      `OFS_COUNT_HI: rdata_next = count_reg[15:8];
      `OFS_CAP2_LO: rdata_next = cap_reg[7:0];
      `OFS_CAP2_HI: rdata_next = cap_reg[15:8];
      `OFS_CTRL: begin
        rdata_next[`CTRL_SELECT_BIT] = capture_or_period_select;
        rdata_next[`CTRL_RUN_BIT] = timer_run;
        rdata_next[`CTRL_EDGE_LO_BIT] = second_capture_edge_sel_lo;
        rdata_next[`CTRL_EDGE_HI_BIT] = second_capture_edge_sel_hi;
        rdata_next[`CTRL_OVF_BIT] = second_capture_overflow;
      end
      `OFS_IRQ_EN: rdata_next = irq_en_reg;
      `OFS_IRQ_REQ: rdata_next = irq_req_vec;
      `OFS_IRQ_CTRL: begin
        rdata_next[`INTC_PERIPHERAL_IRQ_ENABLE_BIT] = peripheral_irq_enable;
        rdata_next[`INTC_GLOBAL_IRQ_DISABLE_BIT] = global_irq_disable;
        rdata_next[`INTC_SUMMARY_BIT] = summary;
      end
      `OFS_PORT: begin
        rdata_next[`PORT_LEVEL_BIT] = cap_level;
        rdata_next[`PORT_DIR_BIT] = port_dir_reg;
      end
      default: rdata_next = 8'h00;
    endcase
  end

endmodule : timer3_period_and_capture

// ### verif/timer3_asserts.sv
`timescale 1ns/100ps
module timer3_asserts (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Pin and requests
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic third_timer_match_req,
  input wire logic second_capture_irq,
  input wire logic peripheral_irq_summary_flag
);
  logic take;
  logic wr_ph;
  logic wr_end;
  assign take = hsel && hready && htrans[1];
  assign wr_end = wr_ph && hready;
  // Marks the data phase of a write, where registers are updated.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
    end else if (hready) begin
      wr_ph <= take && hwrite;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  read_wait_one_a:
    assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read did not take one wait state");
  write_no_wait_a:
    assert property (take && hwrite |=> hreadyout)
    else $error("write was stalled");
  stall_only_read_a:
    assert property (!hreadyout |-> $past(take && !hwrite))
    else $error("stall without a read");
  byte_lane_a:
    assert property (hrdata[31:8] == 24'h0 && !hresp)
    else $error("upper read bits or response wrong");
  rdata_hold_a:
    assert property ($changed(hrdata) |-> $past(!hreadyout))
    else $error("read data changed outside a read");
  match_summary_a:
    assert property (third_timer_match_req |-> peripheral_irq_summary_flag)
    else $error("match request missing from summary");
  capture_summary_a:
    assert property (second_capture_irq |-> peripheral_irq_summary_flag)
    else $error("capture request missing from summary");
  match_sticky_a:
    assert property ($fell(third_timer_match_req) |->
      $past(wr_end) || $past(wr_end, 2) || $past(wr_end, 3))
    else $error("match request dropped without a write");
  capture_sticky_a:
    assert property ($fell(second_capture_irq) |->
      $past(wr_end) || $past(wr_end, 2) || $past(wr_end, 3))
    else $error("capture request dropped without a write");
  port_by_write_a:
    assert property ($changed({pin_out, pin_oe}) |-> $past(wr_end))
    else $error("port pin changed without a write");
endmodule : timer3_asserts

bind timer3_period_and_capture timer3_asserts chk (.hclk, .hresetn,
  .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .pin_out, .pin_oe, .third_timer_match_req, .second_capture_irq,
  .peripheral_irq_summary_flag);

// ### verif/capture_source.sv
`timescale 1ns/100ps
module capture_source (
  // Clock
  input wire logic hclk,
  // Capture pin level
  output logic pin_in
);
  initial pin_in = 1'b0;
  // synchroniser-safe width
  // Each level is held whole clocks so the synchroniser never misses it.
  task automatic pulse(input int hold);
    @(posedge hclk);
    pin_in <= 1'b1;
    repeat (hold) @(posedge hclk);
    pin_in <= 1'b0;
    repeat (hold) @(posedge hclk);
  endtask : pulse
endmodule : capture_source

// ### verif/timer3_period_and_capture_bench.sv
`timescale 1ns/100ps
`include "timer3_params.svh"
module timer3_period_and_capture_bench;
  logic hclk, hresetn, hwrite, hreadyout, hresp;
  logic pin_in, pin_out, pin_oe, mreq, cirq, sumf;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] q, p;
  int err_count, checks, ps;
  logic [7:0] ra [9] = '{`OFS_PERIOD_LO, `OFS_PERIOD_HI, `OFS_COUNT_LO,
    `OFS_CTRL, `OFS_IRQ_EN, `OFS_IRQ_REQ, `OFS_IRQ_CTRL, `OFS_PORT, 8'h2c};
  logic [7:0] rv [9] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02,
    8'h00, 8'h00};
  logic [7:0] wa [5] = '{`OFS_PERIOD_LO, `OFS_PERIOD_HI, `OFS_CAP2_LO,
    `OFS_CAP2_HI, `OFS_IRQ_EN};

  timer3_period_and_capture dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .third_timer_match_req(mreq), .second_capture_irq(cirq),
    .peripheral_irq_summary_flag(sumf));
  capture_source src (.hclk(hclk), .pin_in(pin_in));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One single transfer; returns just after the edge that ends it.
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [7:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata[7:0];
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rdc

  function automatic logic ev_exp(input logic [1:0] s, input logic rise,
    input int n);
    case (s)
      2'b00: return !rise;
      2'b01: return rise;
      2'b10: return rise && n % 4 == 3;
      default: return rise && n % 16 == 15;
    endcase
  endfunction : ev_exp

  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic rw_test;
    logic [7:0] d [5];
    foreach (d[i]) begin
      d[i] = 8'($urandom);
      bus(1'b1, wa[i], d[i]);
    end
    bus(1'b1, 8'h2c, 8'hff);
    foreach (d[i]) rdc(wa[i], d[i]);
    rdc(8'h2c, 8'h00);
  endtask : rw_test

  task automatic period_test;
    p = 8'($urandom_range(6, 40));
    bus(1'b1, `OFS_PERIOD_LO, p);
    bus(1'b1, `OFS_PERIOD_HI, 8'h00);
    bus(1'b1, `OFS_COUNT_LO, 8'h00);
    bus(1'b1, `OFS_COUNT_HI, 8'h00);
    bus(1'b1, `OFS_IRQ_EN, 8'h40);
    bus(1'b1, `OFS_CTRL, 8'h02);
    repeat (12) begin
      bus(1'b0, `OFS_COUNT_LO, 8'h00);
      chk({7'h0, q <= p}, 8'h01);
    end
    repeat (p) @(posedge hclk);
    bus(1'b1, `OFS_CTRL, 8'h00);
    repeat (40) @(posedge hclk);
    chk({7'h0, mreq}, 8'h01);
    rdc(`OFS_IRQ_REQ, 8'h40);
    bus(1'b1, `OFS_IRQ_EN, 8'hbf);
    repeat (2) @(posedge hclk);
    chk({7'h0, mreq}, 8'h00);
    bus(1'b1, `OFS_IRQ_REQ, 8'h00);
    bus(1'b1, `OFS_COUNT_LO, 8'h00);
    bus(1'b1, `OFS_CTRL, 8'h03);
    repeat (50) @(posedge hclk);
    bus(1'b0, `OFS_COUNT_LO, 8'h00);
    chk({7'h0, q > p}, 8'h01);
    bus(1'b1, `OFS_CTRL, 8'h00);
    rdc(`OFS_IRQ_REQ, 8'h00);
    bus(1'b1, `OFS_PERIOD_LO, 8'hff);
    bus(1'b1, `OFS_PERIOD_HI, 8'hff);
  endtask : period_test

  // One pulse on the pin, or through the port latch, with the timer held.
  task automatic edge_test(input logic [1:0] s, input logic up);
    logic [7:0] lo, hi, ie;
    logic [1:0] ic;
    logic e;
    lo = 8'($urandom);
    hi = 8'($urandom_range(0, 254));
    ie = 8'($urandom);
    ic = 2'($urandom);
    e = ev_exp(s, 1'b1, ps) || ev_exp(s, 1'b0, ps);
    ps++;
    bus(1'b1, `OFS_COUNT_LO, lo);
    bus(1'b1, `OFS_COUNT_HI, hi);
    bus(1'b1, `OFS_IRQ_EN, ie);
    bus(1'b1, `OFS_IRQ_CTRL, {6'h0, ic});
    bus(1'b1, `OFS_CTRL, {4'h0, s, 2'b00});
    if (up) begin
      bus(1'b1, `OFS_PORT, 8'h03);
      @(posedge hclk);
      chk({6'h0, pin_oe, pin_out}, 8'h03);
      bus(1'b1, `OFS_PORT, 8'h02);
      bus(1'b1, `OFS_PORT, 8'h00);
    end else begin
      src.pulse($urandom_range(2, 9));
    end
    repeat (6) @(posedge hclk);
    rdc(`OFS_IRQ_REQ, {4'h0, e, 3'h0});
    if (e) begin
      rdc(`OFS_CAP2_LO, lo);
      rdc(`OFS_CAP2_HI, hi);
    end
    @(posedge hclk);
    chk({7'h0, cirq}, {7'h0, e & ie[3] & ic[0] & !ic[1]});
    chk({7'h0, sumf}, {7'h0, e & ie[3]});
    bus(1'b1, `OFS_IRQ_REQ, 8'h00);
  endtask : edge_test

  task automatic ovf_test;
    logic [7:0] a;
    a = 8'($urandom);
    bus(1'b1, `OFS_CTRL, 8'h04);
    bus(1'b1, `OFS_COUNT_LO, a);
    bus(1'b1, `OFS_COUNT_HI, 8'h00);
    src.pulse(3);
    bus(1'b1, `OFS_COUNT_LO, ~a);
    src.pulse(3);
    repeat (6) @(posedge hclk);
    rdc(`OFS_CTRL, 8'h04);
    rdc(`OFS_CAP2_LO, a);
    rdc(`OFS_CAP2_HI, 8'h00);
    rdc(`OFS_CTRL, 8'h14);
    src.pulse(3);
    repeat (6) @(posedge hclk);
    rdc(`OFS_CAP2_HI, 8'h00);
    rdc(`OFS_CAP2_LO, ~a);
    rdc(`OFS_CTRL, 8'h04);
    bus(1'b1, `OFS_IRQ_REQ, 8'h00);
    ps = ps + 3;
  endtask : ovf_test

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial begin
    repeat (30000) @(posedge hclk);
    err_count++;
    results();
  end

  initial begin
    void'($urandom(32'hcfb962de));
    hresetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ra[i]) rdc(ra[i], rv[i]);
    $display("reset values done");
    rw_test();
    $display("byte access done");
    period_test();
    $display("period mode done");
    for (int i = 0; i < 40; i++) begin
      edge_test(i < 4 ? 2'b10 : i < 8 ? 2'(i) : 2'($urandom),
        i > 8 && $urandom_range(0, 3) == 0);
    end
    $display("capture edges done");
    ovf_test();
    $display("overflow done");
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ps = 0;
    repeat (4) edge_test(2'b10, 1'b0);
    $display("second reset done");
    results();
  end
endmodule : timer3_period_and_capture_bench
